// ---- logic/read_cycle_cfg.svh ----
// Purpose: named offsets, fields, reset values and limits of the read cycle sequencer
// Assumes: APB byte addresses, 32-bit aligned registers, 50 MHz clock
// Notes:   definitions only, no logic
`ifndef READ_CYCLE_CFG_SVH
`define READ_CYCLE_CFG_SVH

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define RC_REG_CTRL    8'h00
`define RC_REG_ITER    8'h04
`define RC_REG_LIMIT   8'h08
`define RC_REG_PAUSE   8'h0c
`define RC_REG_CAPS    8'h10
`define RC_REG_STATUS  8'h14
`define RC_REG_COUNT   8'h18

// ----------------------------------------------------------------
// control fields
// ----------------------------------------------------------------
`define RC_CTRL_MODE_LO 0
`define RC_CTRL_MODE_HI 1
`define RC_CTRL_RUN     2
`define RC_CTRL_IMMED   3
`define RC_CTRL_START   4
`define RC_CTRL_STOP    5

// mode codes held in the control register
`define RC_MODE_CONT   2'h0
`define RC_MODE_PRES   2'h1
`define RC_MODE_SS     2'h2

// ----------------------------------------------------------------
// millisecond settings: reset values and upper limits
// ----------------------------------------------------------------
`define RC_ITER_RESET   16'h002d
`define RC_ITER_MAX     16'h2710
`define RC_LIMIT_RESET  16'h01f4
`define RC_LIMIT_MAX    16'h2710
`define RC_PAUSE_RESET  16'h07d0
`define RC_PAUSE_MAX    16'hea60

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define RC_CLOCK_KHZ    50000
`define RC_MS_UNIT      1
`define RC_CLKS_PER_MS  (`RC_CLOCK_KHZ * `RC_MS_UNIT)

`endif

// ---- logic/read_cycle_pkg.sv ----
// Purpose: shared types of the read cycle sequencer
// Assumes: constants live in read_cycle_cfg.svh
// Notes:   state enum only
`default_nettype none

package read_cycle_pkg;

  // sequencer states
  typedef enum logic [2:0] {
    st_idle,
    st_capture,
    st_capwait,
    st_iter,
    st_hold,
    st_report,
    st_pause
  } state_type;

endpackage : read_cycle_pkg

`default_nettype wire

// ---- logic/ms_countdown.sv ----
// Purpose: millisecond countdown driven by a divided tick of the system clock
// Assumes: one clock, synchronous active-high reset
// Notes:   a length of zero expires on the cycle after the load
`timescale 1ns/10ps
`default_nettype none

module ms_countdown #(
  parameter int CLKS_PER_MS = 50000,
  parameter int W           = 16
) (
  input  wire logic         clock,
  input  wire logic         reset,
  input  wire logic         load,
  input  wire logic         cancel,
  input  wire logic [W-1:0] length,
  output logic              expired
);

  localparam int PW = (CLKS_PER_MS > 1) ? $clog2(CLKS_PER_MS) : 1;

  logic [PW-1:0] prescale;   // cycles inside the current millisecond
  logic [W-1:0]  remaining;  // whole milliseconds still to go
  logic          running;    // countdown in progress

  // one-cycle millisecond enable from the divider
  wire tick = running && (prescale == PW'(CLKS_PER_MS - 1));

  // ----------------------------------------------------------------
  // divider and countdown
  // ----------------------------------------------------------------
  // the divider restarts on each load so every wait is a full count
  always_ff @(posedge clock) begin
    if (reset || cancel) begin
      prescale  <= '0;
      remaining <= '0;
      running   <= 1'b0;
      expired   <= 1'b0;
    end else if (load) begin
      prescale  <= '0;
      remaining <= length;
      running   <= (length != '0);
      expired   <= (length == '0);
    end else if (tick) begin
      prescale  <= '0;
      remaining <= remaining - W'(1);
      if (remaining == W'(1)) begin
        running <= 1'b0;
        expired <= 1'b1;
      end
    end else if (running) begin
      prescale <= prescale + PW'(1);
    end
  end

endmodule : ms_countdown

`default_nettype wire

// ---- logic/read_cycle_sequencer.sv ----
// Purpose: read cycle sequencer for continuous, presentation and start/stop modes
// Assumes: capture and decode engines outside, APB register access, 50 MHz clock
// Notes:   all outputs registered; millisecond waits come from ms_countdown
//
// The placing of the registers and the APB register port were decided locally.
`timescale 1ns/10ps
`default_nettype none
`include "read_cycle_cfg.svh"

// Notes on behaviour
// - continuous mode acquires on run without trigger
// - continuous/presentation cycle ends only on good read
// - report first, then next cycle starts
// - first cycle starts automatically when job loaded
// - presentation waits pause after report before restart
// - pause 0..60000 ms, default 2000, presentation only
// - continuous restarts immediately, no inserted wait
// - capture list repeats without limit until found
// - delay between list passes 0..10000, default 45
// - decode instance limited 0..10000 ms, default 500
// - report sent immediately on good read
// - end emits result, outputs and controller data
// - start/stop cycle starts on trigger or command
// - start/stop keeps acquiring while cycle active; code stops capturing in st_hold after a good read, cycle_active stays high
// - start/stop sends data immediately or at stop
// - stop ends cycle; idle until next start
// - iteration delay and limit apply in start/stop
// - unqualified tools at stop terminated, reported failed
// - immediate send holds pass/end outputs until stop
module read_cycle_sequencer #(
  parameter int TOOLS       = 4,
  parameter int CAP_W       = 4,
  parameter int CLKS_PER_MS = `RC_CLKS_PER_MS
) (
  input  wire logic             clock,
  input  wire logic             reset,
  input  wire logic             psel,
  input  wire logic             penable,
  input  wire logic             pwrite,
  input  wire logic [7:0]       paddr,
  input  wire logic [31:0]      pwdata,
  output logic      [31:0]      prdata,
  output logic                  pready,
  output logic                  pslverr,
  input  wire logic             trigger,
  input  wire logic             capture_done,
  input  wire logic             decode_done,
  input  wire logic [TOOLS-1:0] tool_qualified,
  output logic                  capture_start,
  output logic      [CAP_W-1:0] capture_index,
  output logic                  decode_start,
  output logic                  decode_abort,
  output logic                  report_send,
  output logic                  cycle_end,
  output logic                  result_pass,
  output logic      [TOOLS-1:0] tool_failed,
  output logic                  cycle_active
);

  // ----------------------------------------------------------------
  // register bus
  // ----------------------------------------------------------------
  logic [1:0]       mode;          // operating mode code
  logic             run;           // job loaded and running
  logic             immed;         // start/stop: send data as decoded
  logic [15:0]      iter_delay;    // ms between capture list passes
  logic [15:0]      tool_limit;    // ms allowed per decode instance
  logic [15:0]      pause_time;    // ms presentation restart pause
  logic [CAP_W-1:0] last_capture;  // index of last capture in list
  logic [15:0]      cycle_count;   // completed read cycles

  // clamp a written millisecond value to its documented maximum
  function automatic logic [15:0] clamp_ms(input logic [31:0] value, input logic [15:0] limit);
    clamp_ms = (value > {16'h0000, limit}) ? limit : value[15:0];
  endfunction : clamp_ms

  // true for any address that holds a register
  function automatic logic is_mapped(input logic [7:0] addr);
    is_mapped = (addr == `RC_REG_CTRL) || (addr == `RC_REG_ITER) || (addr == `RC_REG_LIMIT) ||
                (addr == `RC_REG_PAUSE) || (addr == `RC_REG_CAPS) ||
                (addr == `RC_REG_STATUS) || (addr == `RC_REG_COUNT);
  endfunction : is_mapped

  // first access cycle gets one wait state; the write lands when pready is seen
  wire access   = psel && penable && !pready;
  wire wr_take  = psel && penable && pready && pwrite && is_mapped(paddr);
  wire wr_ctrl  = wr_take && (paddr == `RC_REG_CTRL);
  wire start_cmd = wr_ctrl && pwdata[`RC_CTRL_START];
  wire stop_cmd  = wr_ctrl && pwdata[`RC_CTRL_STOP];

  read_cycle_pkg::state_type state;
  read_cycle_pkg::state_type next_state;
  logic [TOOLS-1:0] qualified;     // tools qualified in this cycle
  logic             sent_early;    // data already sent this cycle
  logic             dec_busy;      // a decode instance is running

  wire all_qual = &qualified;
  wire [31:0] status_word = {16'h0000, 8'(TOOLS), 1'b0, 3'(state), 1'b0,
                             all_qual, result_pass, cycle_active};

  wire [31:0] rd_value =
    (paddr == `RC_REG_CTRL)   ? {26'h0000000, 1'b0, 1'b0, immed, run, mode} :
    (paddr == `RC_REG_ITER)   ? {16'h0000, iter_delay} :
    (paddr == `RC_REG_LIMIT)  ? {16'h0000, tool_limit} :
    (paddr == `RC_REG_PAUSE)  ? {16'h0000, pause_time} :
    (paddr == `RC_REG_CAPS)   ? 32'(last_capture) :
    (paddr == `RC_REG_STATUS) ? status_word :
    (paddr == `RC_REG_COUNT)  ? {16'h0000, cycle_count} : 32'h00000000;

  // bus answer: pready one cycle into the access phase, error on holes
  always_ff @(posedge clock) begin
    if (reset) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h00000000;
    end else begin
      pready  <= access;
      pslverr <= access && !is_mapped(paddr);
      if (access && !pwrite) begin
        prdata <= rd_value;
      end
    end
  end

  // writable settings; start and stop bits are command pulses, never stored
  always_ff @(posedge clock) begin
    if (reset) begin
      mode         <= `RC_MODE_CONT;
      run          <= 1'b0;
      immed        <= 1'b0;
      iter_delay   <= `RC_ITER_RESET;
      tool_limit   <= `RC_LIMIT_RESET;
      pause_time   <= `RC_PAUSE_RESET;
      last_capture <= '0;
    end else if (wr_take) begin
      if (paddr == `RC_REG_CTRL) begin
        mode  <= pwdata[`RC_CTRL_MODE_HI:`RC_CTRL_MODE_LO];
        run   <= pwdata[`RC_CTRL_RUN];
        immed <= pwdata[`RC_CTRL_IMMED];
      end
      if (paddr == `RC_REG_ITER)  iter_delay <= clamp_ms(pwdata, `RC_ITER_MAX);
      if (paddr == `RC_REG_LIMIT) tool_limit <= clamp_ms(pwdata, `RC_LIMIT_MAX);
      if (paddr == `RC_REG_PAUSE) pause_time <= clamp_ms(pwdata, `RC_PAUSE_MAX);
      if (paddr == `RC_REG_CAPS)  last_capture <= pwdata[CAP_W-1:0];
    end
  end

  // ----------------------------------------------------------------
  // events and timers
  // ----------------------------------------------------------------
  logic trig_prev;                 // trigger one cycle ago
  wire  ss_mode   = (mode == `RC_MODE_SS);
  wire  pres_mode = (mode == `RC_MODE_PRES);
  wire  trig_rise = trigger && !trig_prev;
  wire  trig_fall = !trigger && trig_prev;
  wire  start_evt = ss_mode ? (trig_rise || start_cmd) : run;
  wire  stop_evt  = ss_mode && (trig_fall || stop_cmd);
  wire  in_cycle  = (state == read_cycle_pkg::st_capture) ||
                    (state == read_cycle_pkg::st_capwait) ||
                    (state == read_cycle_pkg::st_iter);
  wire  last_cap  = (capture_index == last_capture);
  wire  cap_taken = (state == read_cycle_pkg::st_capwait) && capture_done;

  // entering the report state from any other; new cycle entering capture from outside it
  wire  to_report = (next_state == read_cycle_pkg::st_report);
  wire  new_cycle = (next_state == read_cycle_pkg::st_capture) && !in_cycle;
  wire  wait_load = (next_state == read_cycle_pkg::st_iter || next_state == read_cycle_pkg::st_pause)
                    && state != next_state;
  wire [15:0] wait_len = (next_state == read_cycle_pkg::st_pause) ? pause_time : iter_delay;
  wire  wait_done;
  wire  limit_done;

  // one timer serves both the pass delay and the presentation pause
  ms_countdown #(.CLKS_PER_MS(CLKS_PER_MS), .W(16)) wait_timer (
    .clock   (clock),
    .reset   (reset),
    .load    (wait_load),
    .cancel  (1'b0),
    .length  (wait_len),
    .expired (wait_done)
  );

  // decode run-time limit, restarted for each decode instance
  ms_countdown #(.CLKS_PER_MS(CLKS_PER_MS), .W(16)) limit_timer (
    .clock   (clock),
    .reset   (reset),
    .load    (cap_taken),
    .cancel  (1'b0),
    .length  (tool_limit),
    .expired (limit_done)
  );

  // ----------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------
  // good read wins over stop and over capture progress in the same cycle
  always_comb begin
    next_state = state;
    case (state)
      read_cycle_pkg::st_idle: begin
        if (start_evt) next_state = read_cycle_pkg::st_capture;
      end
      read_cycle_pkg::st_capture, read_cycle_pkg::st_capwait, read_cycle_pkg::st_iter: begin
        if (all_qual) begin
          next_state = ss_mode ? read_cycle_pkg::st_hold : read_cycle_pkg::st_report;
        end else if (stop_evt) begin
          next_state = read_cycle_pkg::st_report;
        end else if (state == read_cycle_pkg::st_capture) begin
          next_state = read_cycle_pkg::st_capwait;
        end else if (state == read_cycle_pkg::st_capwait) begin
          if (capture_done) begin
            next_state = last_cap ? read_cycle_pkg::st_iter
                                  : read_cycle_pkg::st_capture;
          end
        end else if (wait_done) begin
          next_state = read_cycle_pkg::st_capture;
        end
      end
      read_cycle_pkg::st_hold: begin
        if (stop_evt) next_state = read_cycle_pkg::st_report;
      end
      read_cycle_pkg::st_report: begin
        if (ss_mode)        next_state = read_cycle_pkg::st_idle;
        else if (pres_mode) next_state = read_cycle_pkg::st_pause;
        else                next_state = read_cycle_pkg::st_capture;
      end
      // a switch to start/stop during the pause parks in idle; only a start may begin a cycle
      read_cycle_pkg::st_pause: begin
        if (wait_done) next_state = ss_mode ? read_cycle_pkg::st_idle
                                            : read_cycle_pkg::st_capture;
      end
      default: next_state = read_cycle_pkg::st_idle;
    endcase
  end

  // state register and trigger history
  always_ff @(posedge clock) begin
    if (reset) begin
      state     <= read_cycle_pkg::st_idle;
      trig_prev <= 1'b0;
    end else begin
      state     <= next_state;
      trig_prev <= trigger;
    end
  end

  // qualification is sticky within a cycle; a qualify at cycle start is kept
  always_ff @(posedge clock) begin
    if (reset) begin
      qualified <= '0;
    end else if (new_cycle) begin
      qualified <= tool_qualified;
    end else if (in_cycle) begin
      qualified <= qualified | tool_qualified;
    end
  end

  // capture stepping: list index and one-cycle capture request
  always_ff @(posedge clock) begin
    if (reset) begin
      capture_index <= '0;
      capture_start <= 1'b0;
    end else begin
      capture_start <= (next_state == read_cycle_pkg::st_capture);
      if (new_cycle || (state == read_cycle_pkg::st_iter)) begin
        capture_index <= '0;
      end else if (cap_taken && !last_cap) begin
        capture_index <= capture_index + CAP_W'(1);
      end
    end
  end

  // decode instance launch, run-time limit and termination at cycle end
  always_ff @(posedge clock) begin
    if (reset) begin
      decode_start <= 1'b0;
      decode_abort <= 1'b0;
      dec_busy     <= 1'b0;
    end else begin
      decode_start <= cap_taken;
      decode_abort <= dec_busy && !decode_done && !cap_taken &&
                      (limit_done || to_report);
      if (cap_taken) begin
        dec_busy <= 1'b1;
      end else if (decode_done || limit_done || to_report) begin
        dec_busy <= 1'b0;
      end
    end
  end

  // report outputs; pass and end-of-cycle change only in the report state
  always_ff @(posedge clock) begin
    if (reset) begin
      report_send  <= 1'b0;
      cycle_end    <= 1'b0;
      result_pass  <= 1'b0;
      tool_failed  <= '0;
      sent_early   <= 1'b0;
      cycle_active <= 1'b0;
      cycle_count  <= 16'h0000;
    end else begin
      cycle_active <= (next_state != read_cycle_pkg::st_idle) &&
                      (next_state != read_cycle_pkg::st_pause);
      report_send  <= 1'b0;
      cycle_end    <= 1'b0;
      if (new_cycle) begin
        sent_early <= 1'b0;
      end
      if (next_state == read_cycle_pkg::st_hold && state != read_cycle_pkg::st_hold) begin
        report_send <= immed;
        sent_early  <= immed;
      end
      if (state == read_cycle_pkg::st_report) begin
        report_send <= !sent_early;
        cycle_end   <= 1'b1;
        result_pass <= all_qual;
        tool_failed <= ~qualified;
        cycle_count <= cycle_count + 16'h0001;
      end
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  property p_cont_restart;
    @(posedge clock) disable iff (reset)
    (state == read_cycle_pkg::st_report && mode == `RC_MODE_CONT) |=> capture_start;
  endproperty
  a_cont_restart: assert property (p_cont_restart)
    else $error("continuous mode did not restart at once");

  property p_good_read_only;
    @(posedge clock) disable iff (reset)
    (state == read_cycle_pkg::st_report && !ss_mode) |-> all_qual;
  endproperty
  a_good_read_only: assert property (p_good_read_only)
    else $error("cycle ended without a good read");

  property p_pres_pause;
    @(posedge clock) disable iff (reset)
    (state == read_cycle_pkg::st_report && pres_mode && pause_time != 16'h0000)
      |=> (state == read_cycle_pkg::st_pause) && !capture_start [*2];
  endproperty
  a_pres_pause: assert property (p_pres_pause)
    else $error("presentation restart without pause");

  property p_first_cycle;
    @(posedge clock) disable iff (reset)
    (state == read_cycle_pkg::st_idle && run && !ss_mode) |=> capture_start;
  endproperty
  a_first_cycle: assert property (p_first_cycle)
    else $error("first cycle did not start on run");

  property p_ss_start;
    @(posedge clock) disable iff (reset)
    (state == read_cycle_pkg::st_idle && ss_mode && (trig_rise || start_cmd))
      |=> capture_start ##1 cycle_active;
  endproperty
  a_ss_start: assert property (p_ss_start)
    else $error("start/stop cycle missed its start");

  property p_back_to_back;
    @(posedge clock) disable iff (reset)
    (cap_taken && !last_cap && !all_qual && !stop_evt) |=> capture_start && decode_start;
  endproperty
  a_back_to_back: assert property (p_back_to_back)
    else $error("gap between captures in one pass");

  property p_iter_wait;
    @(posedge clock) disable iff (reset)
    (state == read_cycle_pkg::st_iter && !wait_done && !all_qual && !stop_evt) |=> !capture_start;
  endproperty
  a_iter_wait: assert property (p_iter_wait)
    else $error("next pass started before delay");

  property p_limit_abort;
    @(posedge clock) disable iff (reset)
    (dec_busy && limit_done && !decode_done && !cap_taken) |=> decode_abort && !dec_busy;
  endproperty
  a_limit_abort: assert property (p_limit_abort)
    else $error("decode not terminated at limit");

  property p_hold_outputs;
    @(posedge clock) disable iff (reset)
    (state == read_cycle_pkg::st_hold) |=> $stable(result_pass) && !cycle_end;
  endproperty
  a_hold_outputs: assert property (p_hold_outputs)
    else $error("pass or end output changed before stop");

  property p_ss_idle;
    @(posedge clock) disable iff (reset)
    (state == read_cycle_pkg::st_report && ss_mode)
      |=> (state == read_cycle_pkg::st_idle) && cycle_end && (tool_failed == ~$past(qualified));
  endproperty
  a_ss_idle: assert property (p_ss_idle)
    else $error("start/stop cycle did not end cleanly");

endmodule : read_cycle_sequencer

`default_nettype wire

// ---- dv/engine_model.sv ----
// Purpose: capture and decode engine on the far side of the sequencer
// Assumes: one clock, pulses in from the sequencer
// Notes:   qualify_all makes every tool qualify after a decode
`timescale 1ns/10ps
`default_nettype none

module engine_model #(
  parameter int TOOLS = 4
) (
  input  wire logic             clock,
  input  wire logic             reset,
  input  wire logic             capture_start,
  input  wire logic             decode_start,
  input  wire logic             qualify_all,
  output logic                  capture_done,
  output logic                  decode_done,
  output logic      [TOOLS-1:0] tool_qualified
);
  logic [1:0] wait_count; // cycles left in a capture

  // capture answers slowly so back to back captures are not free
  always_ff @(posedge clock) begin
    capture_done   <= 1'b0;
    decode_done    <= decode_start;
    tool_qualified <= (decode_start && qualify_all) ? '1 : '0;
    if (reset) begin
      wait_count <= 2'h0;
    end else if (capture_start) begin
      wait_count <= 2'h3;
    end else if (wait_count != 2'h0) begin
      wait_count   <= wait_count - 2'h1;
      capture_done <= (wait_count == 2'h1);
    end
  end
endmodule : engine_model

`default_nettype wire

// ---- dv/test_read_cycle_sequencer.sv ----
// Purpose: self-checking bench of the read cycle sequencer
// Assumes: CLKS_PER_MS of 4, so one ms is four clocks
// Notes:   the bench plays the host; engine_model plays the engines
`timescale 1ns/10ps
`default_nettype none
`include "read_cycle_cfg.svh"

module test_read_cycle_sequencer;
  logic        clock, reset, psel, penable, pwrite, trigger, qual;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, q;
  logic        pready, pslverr, err, c_done, d_done, c_start, d_start;
  logic        d_abort, report_send, cycle_end, result_pass, cycle_active;
  logic [3:0]  tq, tool_failed, cap_idx;
  int          n_errors = 0, n_checks = 0, n;

  read_cycle_sequencer #(.CLKS_PER_MS(4)) u_dut (.clock(clock), .reset(reset),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .trigger(trigger),
    .capture_done(c_done), .decode_done(d_done), .tool_qualified(tq),
    .capture_start(c_start), .capture_index(cap_idx), .decode_start(d_start),
    .decode_abort(d_abort), .report_send(report_send), .cycle_end(cycle_end),
    .result_pass(result_pass), .tool_failed(tool_failed), .cycle_active(cycle_active));
  engine_model u_eng (.clock(clock), .reset(reset), .capture_start(c_start),
    .decode_start(d_start), .qualify_all(qual), .capture_done(c_done),
    .decode_done(d_done), .tool_qualified(tq));

  // compare and count
  task automatic check(input string what, input logic [31:0] seen, exp);
    n_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  // one apb transfer; waits for pready under a bound
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge clock);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge clock);
      k++;
    end while (pready !== 1'b1 && k < 50);
    if (pready !== 1'b1) n_errors++;
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // wait for cycle_end (sel 0), capture_start (sel 1) or report_send (sel 2), counting edges
  task automatic wait_sig(input int sel, input int limit);
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while ((sel == 2 ? report_send : sel == 1 ? c_start : cycle_end) !== 1'b1 && n < limit);
  endtask : wait_sig

  task automatic conclude();
    if (n_errors == 0 && n_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : conclude

  // ----------------------------------------------------------------
  // stimulus
  // ----------------------------------------------------------------
  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end

  initial begin
    #400000;
    n_errors++;
    conclude();
  end

  initial begin
    {reset, psel, penable, pwrite, trigger, qual, paddr, pwdata} = '0;
    reset = 1'b1;
    repeat (10) @(posedge clock);
    reset <= 1'b0;
    // register defaults, clamp and unmapped place
    apb(0, `RC_REG_ITER, 0);  check("iter", q, 32'h2d);
    apb(0, `RC_REG_LIMIT, 0); check("limit", q, 32'h1f4);
    apb(0, `RC_REG_PAUSE, 0); check("pause", q, 32'h7d0);
    apb(1, `RC_REG_PAUSE, 32'hffff);
    apb(0, `RC_REG_PAUSE, 0); check("clamp", q, 32'hea60);
    apb(0, 8'h40, 0); check("slverr", err, 1);
    // continuous: no good read never ends, then report and instant restart
    apb(1, `RC_REG_ITER, 0);
    apb(1, `RC_REG_CTRL, 32'h4);
    wait_sig(1, 20); check("auto", n < 20, 1);
    wait_sig(0, 300); check("no end", cycle_end, 0);
    qual <= 1'b1;
    wait_sig(0, 300);
    check("report", report_send, 1);
    check("restart", c_start, 1);
    check("pass", result_pass, 1);
    // presentation: restart held off by the pause
    apb(1, `RC_REG_CTRL, 32'h0);
    wait_sig(0, 300);
    apb(1, `RC_REG_PAUSE, 32'h2);
    apb(1, `RC_REG_CTRL, 32'h5);
    // the first end may still be a continuous one landing with the mode write
    wait_sig(0, 300);
    wait_sig(0, 300);
    check("no restart", c_start, 0);
    wait_sig(1, 300); check("paused", n >= 8, 1);
    apb(1, `RC_REG_CTRL, 32'h1);
    wait_sig(0, 300);
    // start/stop: trigger starts, trigger fall ends with failed tools
    apb(1, `RC_REG_CTRL, 32'h2);
    // two captures per pass, a pass delay and a zero decode limit exercise the stepping
    apb(1, `RC_REG_CAPS, 1);
    apb(1, `RC_REG_ITER, 1);
    apb(1, `RC_REG_LIMIT, 0);
    repeat (8) @(posedge clock);
    qual <= 1'b0;
    trigger <= 1'b1;
    wait_sig(1, 20); check("trig start", n < 20, 1);
    repeat (30) @(posedge clock);
    trigger <= 1'b0;
    wait_sig(0, 50);
    check("stop end", cycle_end, 1);
    check("failed", {28'h0, tool_failed}, 32'hf);
    repeat (5) @(posedge clock);
    check("idle", cycle_active, 0);
    // start/stop, immediate send: data at good read, pass and end held until stop
    apb(1, `RC_REG_CTRL, 32'ha);
    qual <= 1'b1;
    trigger <= 1'b1;
    wait_sig(2, 60); check("early send", n < 60, 1);
    check("end held", cycle_end, 0);
    check("pass held", result_pass, 0);
    repeat (10) @(posedge clock);
    trigger <= 1'b0;
    wait_sig(0, 50);
    check("pass at stop", result_pass, 1);
    check("no resend", report_send, 0);
    conclude();
  end
endmodule : test_read_cycle_sequencer

`default_nettype wire
